// *** hdl/scl_pkg.sv ***
// shared constants and types for the synthesizer control latches
package scl_pkg;
    localparam int WORD_BITS = 24;
    // latch select codes in bits 1:0
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REF = 2'h1;
    localparam logic [1:0] SEL_FEEDBACK = 2'h2;
    // control latch fields
    localparam int CTL_PRESCALER_LSB = 22;
    localparam int CTL_PD_SYNC = 21;
    localparam int CTL_PD_REQ = 20;
    localparam int CTL_CUR_B_LSB = 17;
    localparam int CTL_CUR_A_LSB = 14;
    localparam int CTL_MUTE = 11;
    localparam int CTL_GAIN = 10;
    localparam int CTL_PUMP_OFF = 9;
    localparam int CTL_POLARITY = 8;
    localparam int CTL_CNT_RESET = 4;
    // feedback latch fields
    localparam int FB_DIV_SEL = 23;
    localparam int FB_DIV_OUT = 22;
    localparam int FB_GAIN = 21;
    localparam int FB_MAIN_LSB = 8;
    localparam int FB_SWALLOW_LSB = 2;
    localparam int SWALLOW_BITS = 5;
    localparam int MAIN_BITS = 13;
    localparam logic [23:0] WORD_RESET = 24'h000000;
    // prescaler moduli: 8, 16, 32 (code 3 treated as 32)
    localparam logic [5:0] PRESCALE_8 = 6'h08;
    localparam logic [5:0] PRESCALE_16 = 6'h10;
    localparam logic [5:0] PRESCALE_32 = 6'h20;
    // synchronous power-down waits this many reference edges
    localparam logic [1:0] SYNC_PD_EDGES = 2'h2;

    typedef struct packed {
        logic [2:0] pump_current;
        logic pump_off;
        logic polarity_positive;
        logic counters_reset;
        logic outputs_enabled;
        logic ref_buffer_on;
        logic counters_load;
        logic lock_detect_reset;
        logic halve_output;
        logic halve_prescaler_in;
    } scl_analog_type;
endpackage

// *** hdl/scl_pin_sync.sv ***
// three-stage synchroniser with agreement filter and edge detection
`timescale 1ns/1ps
module scl_pin_sync
    import scl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin
    input wire logic pin,
    // filtered result
    output logic level,
    output logic rise
);
    logic s1;
    logic s2;
    logic s3;
    wire agree = (s2 == s3);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (agree)
                level <= s3;
        end
    end

    assign rise = agree && s3 && !level;
endmodule // scl_pin_sync

// *** hdl/scl_feedback_calc.sv ***
// total feedback division from prescaler, main and swallow counts
`timescale 1ns/1ps
module scl_feedback_calc
    import scl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // latch fields
    input wire logic [1:0] prescaler_code,
    input wire logic [MAIN_BITS-1:0] main_count,
    input wire logic [SWALLOW_BITS-1:0] swallow_count,
    // result
    output logic [18:0] divide_total
);
    wire [5:0] modulus = (prescaler_code == 2'h0) ? PRESCALE_8 :
                         (prescaler_code == 2'h1) ? PRESCALE_16 : PRESCALE_32;
    // widen both factors first, else the product is cut to the count width
    wire [18:0] product = 19'(modulus) * 19'(main_count);
    wire [18:0] next_divide_total = product + 19'(swallow_count);

    always_ff @(posedge clk)
    begin
        if (rst)
            divide_total <= 19'h00000;
        else
            divide_total <= next_divide_total; // R20
    end
endmodule // scl_feedback_calc

// *** hdl/scl_control_latches.sv ***
// serial shift register, latches and power-down control of the synthesizer
//
// Overview of operation
// R1 - host programs reference latch, then control latch, then feedback latch after power-up.
// R2 - host waits 5 ms (10 uF) or 600 us (440 nF) before feedback latch.
// R3 - select bits 00 load the word into the control latch.
// R4 - select bits 10 load the word into the feedback divider latch.
// R5 - request bit 1 with sync bit 0 powers down immediately.
// R6 - both bits 1 power down on second reference edge after load strobe.
// R7 - chip enable low disables the device at once regardless of bits.
// R8 - power-down loads counters, stops pump, resets lock, mutes outputs, stops buffer.
// R9 - serial register keeps shifting and latching during power-down.
// R10 - host must not change feedback count in power-down, else reprogram all.
// R11 - unchanged feedback count relocks in same band after power-up.
// R12 - mute-until-lock keeps outputs off until loop reports lock.
// R13 - gain bit chooses upper current setting when 1, lower when 0.
// R14 - gain bit also written via feedback latch; latest write wins.
// R15 - pump-off bit places charge pump in high impedance.
// R16 - polarity bit 1 positive, 0 inverted.
// R17 - counter reset bit holds reference and A/B counters in reset.
// R18 - swallow count is 5 bits, 0 to 31.
// R19 - main count 13 bits, 3 to 8191; bit 7 written as zero.
// R20 - total division is prescaler times main count plus swallow count.
// R21 - output divide bit routes halved frequency to output.
// R22 - divide select bit feeds halved signal to the prescaler.
// R23 - 24 bits shift in on serial clock rises; strobe rise latches.
// R24 - select bits 01 load the word into the reference latch.
// R25 - host sends MSB first, select bits in the two lowest bits.
`timescale 1ns/1ps
module scl_control_latches
    import scl_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // three-wire serial link
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_DATA,
    input wire logic LOAD_STROBE,
    // chip enable pin, active high
    input wire logic CHIP_ENABLE,
    // reference counter output and loop lock indication
    input wire logic REF_COUNTER_OUT,
    input wire logic LOOP_LOCKED,
    // latched words
    output logic [WORD_BITS-1:0] CONTROL_WORD_LATCH,
    output logic [WORD_BITS-1:0] FEEDBACK_DIVIDER_LATCH,
    output logic [WORD_BITS-1:0] REFERENCE_LATCH,
    // analog controls
    output scl_analog_type ANALOG_CTRL,
    output logic [18:0] DIVIDE_TOTAL,
    output logic POWERED_DOWN
);
    logic sclk_level;
    logic sclk_rise;
    logic data_level;
    logic le_level;
    logic le_rise;
    logic ce_level;
    logic ref_level;
    logic ref_rise;
    logic lock_level;
    logic [WORD_BITS-1:0] shift_word;
    logic [WORD_BITS-1:0] next_shift_word;
    logic gain;
    logic pd_soft;
    logic [1:0] ref_edges;
    logic sync_pending;

    // slow pins all pass the three-stage filter; link clock at 160 ns is well sampled
    scl_pin_sync u_sclk (.clk(MCLK), .rst(RST), .pin(SERIAL_CLK), .level(sclk_level),
        .rise(sclk_rise));
    scl_pin_sync u_data (.clk(MCLK), .rst(RST), .pin(SERIAL_DATA), .level(data_level),
        .rise());
    scl_pin_sync u_le (.clk(MCLK), .rst(RST), .pin(LOAD_STROBE), .level(le_level),
        .rise(le_rise));
    scl_pin_sync u_ce (.clk(MCLK), .rst(RST), .pin(CHIP_ENABLE), .level(ce_level),
        .rise());
    scl_pin_sync u_ref (.clk(MCLK), .rst(RST), .pin(REF_COUNTER_OUT), .level(ref_level),
        .rise(ref_rise));
    scl_pin_sync u_lock (.clk(MCLK), .rst(RST), .pin(LOOP_LOCKED), .level(lock_level),
        .rise());

    // msb first, so shift toward the top
    assign next_shift_word = {shift_word[WORD_BITS-2:0], data_level}; // R23 R25

    // latch decode
    wire [1:0] sel = shift_word[1:0];
    wire load_ctl = le_rise && (sel == SEL_CONTROL); // R3
    wire load_fb = le_rise && (sel == SEL_FEEDBACK); // R4
    wire load_ref = le_rise && (sel == SEL_REF); // R24
    wire new_req = shift_word[CTL_PD_REQ];
    wire new_sync = shift_word[CTL_PD_SYNC];
    wire async_pd = load_ctl && new_req && !new_sync; // R5
    wire sync_arm = load_ctl && new_req && new_sync; // R6
    wire pd_clear = load_ctl && !new_req;

    // shifting stays alive in power-down: nothing below gates it on power state
    always_ff @(posedge MCLK)
    begin
        if (RST)
            shift_word <= WORD_RESET;
        else if (sclk_rise)
            shift_word <= next_shift_word; // R9 R23
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            CONTROL_WORD_LATCH <= WORD_RESET;
            FEEDBACK_DIVIDER_LATCH <= WORD_RESET;
            REFERENCE_LATCH <= WORD_RESET;
        end
        else
        begin
            if (load_ctl)
                CONTROL_WORD_LATCH <= shift_word; // R3
            if (load_fb)
                FEEDBACK_DIVIDER_LATCH <= shift_word; // R4 R19
            if (load_ref)
                REFERENCE_LATCH <= shift_word; // R24
        end
    end

    // shared gain bit: whichever latch was written last
    always_ff @(posedge MCLK)
    begin
        if (RST)
            gain <= 1'b0;
        else if (load_ctl)
            gain <= shift_word[CTL_GAIN]; // R14
        else if (load_fb)
            gain <= shift_word[FB_GAIN]; // R14
    end

    // synchronous power-down counts reference edges from the strobe rise
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            pd_soft <= 1'b0;
            sync_pending <= 1'b0;
            ref_edges <= 2'h0;
        end
        else if (async_pd)
        begin
            pd_soft <= 1'b1; // R5
            sync_pending <= 1'b0;
        end
        else if (sync_arm)
        begin
            sync_pending <= 1'b1;
            ref_edges <= 2'h0;
        end
        else if (pd_clear)
        begin
            pd_soft <= 1'b0;
            sync_pending <= 1'b0;
        end
        else if (sync_pending && ref_rise)
        begin
            ref_edges <= ref_edges + 2'h1;
            if (ref_edges + 2'h1 == SYNC_PD_EDGES)
            begin
                pd_soft <= 1'b1; // R6
                sync_pending <= 1'b0;
            end
        end
    end

    // pin disable overrides both software bits
    wire powered_down = !ce_level || pd_soft; // R7
    // relock relies on latches surviving power-down untouched
    wire active = !powered_down; // R11

    wire [2:0] cur_a = CONTROL_WORD_LATCH[CTL_CUR_A_LSB +: 3];
    wire [2:0] cur_b = CONTROL_WORD_LATCH[CTL_CUR_B_LSB +: 3];
    wire [2:0] pump_current = gain ? cur_b : cur_a; // R13
    wire pump_off = CONTROL_WORD_LATCH[CTL_PUMP_OFF] || powered_down; // R8 R15
    wire mute = CONTROL_WORD_LATCH[CTL_MUTE] && !lock_level; // R12
    wire cnt_reset = CONTROL_WORD_LATCH[CTL_CNT_RESET]; // R17

    scl_analog_type next_analog;
    always_comb
    begin
        next_analog.pump_current = pump_current;
        next_analog.pump_off = pump_off;
        next_analog.polarity_positive = CONTROL_WORD_LATCH[CTL_POLARITY]; // R16
        next_analog.counters_reset = cnt_reset || powered_down; // R17
        next_analog.outputs_enabled = active && !mute; // R8 R12
        next_analog.ref_buffer_on = active; // R8
        next_analog.counters_load = powered_down; // R8
        next_analog.lock_detect_reset = powered_down; // R8
        next_analog.halve_output = FEEDBACK_DIVIDER_LATCH[FB_DIV_OUT]; // R21
        next_analog.halve_prescaler_in = FEEDBACK_DIVIDER_LATCH[FB_DIV_SEL]; // R22
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            ANALOG_CTRL <= '0;
            POWERED_DOWN <= 1'b1;
        end
        else
        begin
            ANALOG_CTRL <= next_analog;
            POWERED_DOWN <= powered_down;
        end
    end

    scl_feedback_calc u_calc (
        .clk(MCLK),
        .rst(RST),
        .prescaler_code(CONTROL_WORD_LATCH[CTL_PRESCALER_LSB +: 2]),
        .main_count(FEEDBACK_DIVIDER_LATCH[FB_MAIN_LSB +: MAIN_BITS]), // R19
        .swallow_count(FEEDBACK_DIVIDER_LATCH[FB_SWALLOW_LSB +: SWALLOW_BITS]), // R18
        .divide_total(DIVIDE_TOTAL)
    );
endmodule // scl_control_latches

// *** verif/scl_assertions.sv ***
// concurrent checks on the synthesizer control latch ports
`timescale 1ns/1ps
module scl_assertions
    import scl_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // pins
    input wire logic CHIP_ENABLE,
    input wire logic LOOP_LOCKED,
    // results
    input wire logic [WORD_BITS-1:0] CONTROL_WORD_LATCH,
    input wire logic [WORD_BITS-1:0] FEEDBACK_DIVIDER_LATCH,
    input wire scl_analog_type ANALOG_CTRL,
    input wire logic POWERED_DOWN
);
    logic [23:0] cw;
    logic [23:0] fw;
    scl_analog_type a;
    assign cw = CONTROL_WORD_LATCH;
    assign fw = FEEDBACK_DIVIDER_LATCH;
    assign a = ANALOG_CTRL;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    gain_ctrl_a: assert property ($changed(cw) |=> a.pump_current == (cw[10] ? cw[19:17] : cw[16:14]))
        else $error("pump current wrong after control write");
    gain_fb_a: assert property ($changed(fw) |=> a.pump_current == (fw[21] ? cw[19:17] : cw[16:14]))
        else $error("pump current wrong after feedback write");
    pump_off_a: assert property (cw[9] ##1 $stable(cw) |-> a.pump_off)
        else $error("pump not off");
    polarity_a: assert property ($stable(cw) [*2] |-> a.polarity_positive == cw[8])
        else $error("polarity wrong");
    cnt_reset_a: assert property (cw[4] ##1 $stable(cw) |-> a.counters_reset)
        else $error("counters not held");
    mute_lock_a: assert property ((cw[11] && !LOOP_LOCKED) [*6] |-> !a.outputs_enabled)
        else $error("outputs on before lock");
    pd_async_a: assert property ($changed(cw) && cw[21:20] == 2'h1 |-> ##[0:2] POWERED_DOWN)
        else $error("no immediate power-down");
    pd_sync_a: assert property ($changed(cw) && cw[21:20] == 2'h3 && !POWERED_DOWN |=> !POWERED_DOWN)
        else $error("synchronous power-down too early");
    ce_low_a: assert property (!CHIP_ENABLE [*8] |-> POWERED_DOWN)
        else $error("chip enable low but running");
    pd_effects_a: assert property (POWERED_DOWN [*3] |-> !a.outputs_enabled && !a.ref_buffer_on
        && a.counters_load && a.lock_detect_reset && a.pump_off)
        else $error("power-down side effects missing");
    halve_a: assert property ($stable(fw) [*2] |-> {a.halve_prescaler_in, a.halve_output} == fw[23:22])
        else $error("divide-by-2 routing wrong");
    cover property ($changed(cw) && cw[21:20] == 2'h3);
    cover property ($rose(POWERED_DOWN));
    cover property ($changed(fw));
endmodule // scl_assertions

bind scl_control_latches scl_assertions u_chk (.MCLK, .RST, .CHIP_ENABLE, .LOOP_LOCKED,
    .CONTROL_WORD_LATCH, .FEEDBACK_DIVIDER_LATCH, .ANALOG_CTRL, .POWERED_DOWN);

// *** verif/scl_host_model.sv ***
// behavioural host driving the three-wire programming link
`timescale 1ns/1ps
module scl_host_model
(
    // three-wire link
    output logic sclk,
    output logic sdata,
    output logic strobe
);
    initial {sclk, sdata, strobe} = 3'h0;
    // link clock stands still between words
    task automatic send(input logic [23:0] w);
        // step off the system clock edge so no pin moves as it is sampled
        #2;
        for (int i = 23; i >= 0; i--)
        begin
            sdata = w[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #80 strobe = 1'b1;
        // stale data inverted so a missed hold shows up
        sdata = ~w[0];
        #160 strobe = 1'b0;
    endtask
endmodule // scl_host_model

// *** verif/testbench.sv ***
// self-checking bench for the synthesizer control latches
`timescale 1ns/1ps
module testbench
    import scl_pkg::*;
;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, refo = 1'b0, lock = 1'b0;
    logic sclk, sdata, strobe, pd;
    logic [23:0] cw, fw, rw;
    logic [18:0] dt;
    scl_analog_type a;
    int n_mismatch = 0, checked = 0, cycles = 0;
    scl_host_model u_host (.sclk(sclk), .sdata(sdata), .strobe(strobe));
    scl_control_latches u_dut (.MCLK(mclk), .RST(rst), .SERIAL_CLK(sclk), .SERIAL_DATA(sdata),
        .LOAD_STROBE(strobe), .CHIP_ENABLE(ce), .REF_COUNTER_OUT(refo), .LOOP_LOCKED(lock),
        .CONTROL_WORD_LATCH(cw), .FEEDBACK_DIVIDER_LATCH(fw), .REFERENCE_LATCH(rw),
        .ANALOG_CTRL(a), .DIVIDE_TOTAL(dt), .POWERED_DOWN(pd));
    always #5 mclk = ~mclk;
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [23:0] w);
        u_host.send(w);
        repeat (12) @(posedge mclk);
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            refo <= 1'b1;
            repeat (6) @(posedge mclk);
            refo <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask
    // f is {mute, gain, pump off, polarity}; currents 5 and 2
    function automatic logic [23:0] ctl(input logic [1:0] p, input logic [1:0] d,
        input logic [3:0] f, input logic cr);
        return {p, d, 6'h2A, 2'h0, f, 3'h0, cr, 4'h0};
    endfunction
    function automatic logic [23:0] fb(input logic [2:0] t, input logic [12:0] b,
        input logic [4:0] n);
        return {t, b, 1'b0, n, 2'h2};
    endfunction
    task automatic t_order;
        wr(24'h000009);
        check(rw, 24'h000009);
        wr(ctl(2'h1, 2'h0, 4'h1, 1'b0));
        check(cw, ctl(2'h1, 2'h0, 4'h1, 1'b0));
        // settle interval scaled down to keep the run short
        repeat (500) @(posedge mclk);
        wr(fb(3'h0, 13'h0003, 5'h1F));
        check(fw, fb(3'h0, 13'h0003, 5'h1F));
        check(dt, 19'h4F);
        wr(24'hFFFFFF);
        check(rw, 24'h000009);
        $display("order test done");
    endtask
    task automatic t_fields;
        for (int p = 0; p < 4; p++)
        begin
            wr(ctl(p[1:0], 2'h0, {1'b0, p[0], p[1], ~p[0]}, 1'b0));
            check(a.pump_current, p[0] ? 3'h5 : 3'h2);
            check(a.pump_off, p[1]);
            check(a.polarity_positive, !p[0]);
            // code 3 acts as modulus 32
            check(dt, (19'h8 << (p[1] ? 2 : p)) * 19'h3 + 19'h1F);
        end
        wr(fb(3'h6, 13'h1FFF, 5'h00));
        check(a.pump_current, 3'h2);
        check({a.halve_prescaler_in, a.halve_output}, 2'h3);
        check(dt, 19'h20 * 19'h1FFF);
        wr(ctl(2'h1, 2'h0, 4'h4, 1'b1));
        check(a.pump_current, 3'h5);
        check(a.counters_reset, 1'b1);
        wr(ctl(2'h1, 2'h0, 4'h8, 1'b0));
        check(a.counters_reset, 1'b0);
        check(a.outputs_enabled, 1'b0);
        lock <= 1'b1;
        repeat (8) @(posedge mclk);
        check(a.outputs_enabled, 1'b1);
        $display("field test done");
    endtask
    task automatic t_pd;
        wr(ctl(2'h1, 2'h1, 4'h0, 1'b0));
        check(pd, 1'b1);
        check({a.outputs_enabled, a.ref_buffer_on, a.counters_load, a.lock_detect_reset,
            a.pump_off}, 5'h07);
        wr(24'h000015);
        check(rw, 24'h000015);
        wr(ctl(2'h1, 2'h0, 4'h0, 1'b0));
        check(pd, 1'b0);
        wr(ctl(2'h1, 2'h3, 4'h0, 1'b0));
        tick(1);
        check(pd, 1'b0);
        tick(1);
        check(pd, 1'b1);
        wr(ctl(2'h1, 2'h0, 4'h0, 1'b0));
        ce <= 1'b0;
        repeat (10) @(posedge mclk);
        check(pd, 1'b1);
        ce <= 1'b1;
        repeat (10) @(posedge mclk);
        check(pd, 1'b0);
        $display("power-down test done");
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_mismatch++;
            results;
        end
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        t_order;
        t_fields;
        t_pd;
        results;
    end
endmodule // testbench
